// ---- core/seg_top.sv ----
// How it works
// - Questionable falling edge sets event if filtered
// - Sweep in progress is condition bit three
// - Operation summary drives status byte bit seven
// - Events stay latched until host reads
// - Event read returns value then clears
// - No filter enabled means no event
// - Operation falling edge sets event if filtered
// - Operation rising edge sets event if filtered
// - Questionable summary drives status byte bit three
// - Condition registers track live, reads harmless
//
// The strobed register port and the placing of the registers were left to the implementer.
module seg_top
    import seg_pkg::*;
#(
    parameter int W = SEG_DW
) (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic [W-1:0]      oper_state,
    input  wire logic [W-1:0]      ques_state,
    input  wire logic              sweeping,
    input  wire logic [SEG_AW-1:0] addr,
    input  wire logic [SEG_DW-1:0] wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [SEG_DW-1:0] rdata,
    output logic      [7:0]        status_byte,
    output logic                   irq
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // Live states come from other logic domains, so two stages each
    logic [W-1:0] oper_s1_ff;
    logic [W-1:0] oper_s2_ff;
    logic [W-1:0] ques_s1_ff;
    logic [W-1:0] ques_s2_ff;
    logic         swp_s1_ff;
    logic         swp_s2_ff;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            oper_s1_ff <= W'(RST_REG);
            oper_s2_ff <= W'(RST_REG);
            ques_s1_ff <= W'(RST_REG);
            ques_s2_ff <= W'(RST_REG);
            swp_s1_ff  <= 1'b0;
            swp_s2_ff  <= 1'b0;
        end else begin
            oper_s1_ff <= oper_state;
            oper_s2_ff <= oper_s1_ff;
            ques_s1_ff <= ques_state;
            ques_s2_ff <= ques_s1_ff;
            swp_s1_ff  <= sweeping;
            swp_s2_ff  <= swp_s1_ff;
        end
    end

    // ------------------------------------------------------------
    // Condition registers
    // ------------------------------------------------------------
    logic [W-1:0] oper_cond;
    logic [W-1:0] ques_cond;
    logic [W-1:0] swp_mask;

    assign swp_mask  = W'(1) << POS_SWEEPING;
    // Sweep flag forced into its weighted slot
    assign oper_cond = swp_s2_ff ? (oper_s2_ff | swp_mask)
                                 : (oper_s2_ff & ~swp_mask);
    assign ques_cond = ques_s2_ff;

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    seg_req_t req;
    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    logic wr_oper_en;
    logic wr_oper_rise;
    logic wr_oper_fall;
    logic wr_ques_en;
    logic wr_ques_rise;
    logic wr_ques_fall;
    logic wr_irq_stat;
    logic wr_irq_mask;
    logic rd_oper_evt;
    logic rd_ques_evt;

    assign wr_oper_en   = req.wr && (req.addr == OFS_OPER_EN);
    assign wr_oper_rise = req.wr && (req.addr == OFS_OPER_RISE);
    assign wr_oper_fall = req.wr && (req.addr == OFS_OPER_FALL);
    assign wr_ques_en   = req.wr && (req.addr == OFS_QUES_EN);
    assign wr_ques_rise = req.wr && (req.addr == OFS_QUES_RISE);
    assign wr_ques_fall = req.wr && (req.addr == OFS_QUES_FALL);
    assign wr_irq_stat  = req.wr && (req.addr == OFS_IRQ_STAT);
    assign wr_irq_mask  = req.wr && (req.addr == OFS_IRQ_MASK);
    assign rd_oper_evt  = req.rd && (req.addr == OFS_OPER_EVT);
    assign rd_ques_evt  = req.rd && (req.addr == OFS_QUES_EVT);

    // ------------------------------------------------------------
    // Mask and filter registers
    // ------------------------------------------------------------
    logic [W-1:0] oper_en_ff;
    logic [W-1:0] oper_rise_ff;
    logic [W-1:0] oper_fall_ff;
    logic [W-1:0] ques_en_ff;
    logic [W-1:0] ques_rise_ff;
    logic [W-1:0] ques_fall_ff;

    // Weighted-sum value stored verbatim and read back
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            oper_en_ff   <= W'(RST_REG);
            oper_rise_ff <= W'(RST_REG);
            oper_fall_ff <= W'(RST_REG);
            ques_en_ff   <= W'(RST_REG);
            ques_rise_ff <= W'(RST_REG);
            ques_fall_ff <= W'(RST_REG);
        end else begin
            if (wr_oper_en)   oper_en_ff   <= req.wdata[W-1:0];
            if (wr_oper_rise) oper_rise_ff <= req.wdata[W-1:0];
            if (wr_oper_fall) oper_fall_ff <= req.wdata[W-1:0];
            if (wr_ques_en)   ques_en_ff   <= req.wdata[W-1:0];
            if (wr_ques_rise) ques_rise_ff <= req.wdata[W-1:0];
            if (wr_ques_fall) ques_fall_ff <= req.wdata[W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Event groups
    // ------------------------------------------------------------
    logic [W-1:0] oper_evt;
    logic [W-1:0] ques_evt;
    logic         oper_sum;
    logic         ques_sum;
    logic         oper_new;
    logic         ques_new;

    seg_group #(.W(W)) u_oper (
        .ref_clk          (ref_clk),
        .rst              (rst),
        .cond             (oper_cond),
        .rise_edge_filter (oper_rise_ff),
        .fall_edge_filter (oper_fall_ff),
        .enable           (oper_en_ff),
        .evt_read         (rd_oper_evt),
        .event_reg        (oper_evt),
        .summary          (oper_sum),
        .new_event        (oper_new)
    );

    seg_group #(.W(W)) u_ques (
        .ref_clk          (ref_clk),
        .rst              (rst),
        .cond             (ques_cond),
        .rise_edge_filter (ques_rise_ff),
        .fall_edge_filter (ques_fall_ff),
        .enable           (ques_en_ff),
        .evt_read         (rd_ques_evt),
        .event_reg        (ques_evt),
        .summary          (ques_sum),
        .new_event        (ques_new)
    );

    // ------------------------------------------------------------
    // Status byte
    // ------------------------------------------------------------
    logic [7:0] stb;
    always_comb begin
        stb               = 8'h00;
        stb[POS_STB_OPER] = oper_sum;
        stb[POS_STB_QUES] = ques_sum;
    end
    assign status_byte = stb;

    // ------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------
    logic [IRQ_W-1:0] irq_stat_ff;
    logic [IRQ_W-1:0] irq_mask_ff;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] nxt_irq_stat;

    assign irq_set[IRQ_OPER] = oper_new;
    assign irq_set[IRQ_QUES] = ques_new;
    // Set beats a simultaneous write-one clear
    assign nxt_irq_stat = (irq_stat_ff
                          & ~(wr_irq_stat ? req.wdata[IRQ_W-1:0]
                                          : {IRQ_W{1'b0}}))
                          | irq_set;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_stat_ff <= RST_IRQ;
            irq_mask_ff <= RST_IRQ;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
            if (wr_irq_mask) irq_mask_ff <= req.wdata[IRQ_W-1:0];
        end
    end

    assign irq = |(irq_stat_ff & irq_mask_ff);

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Unmapped offsets read zero; condition reads have no side effect
    logic [SEG_DW-1:0] rd_mux;
    logic [SEG_DW-1:0] rdata_ff;

    always_comb begin
        rd_mux = {SEG_DW{1'b0}};
        unique case (req.addr)
            OFS_OPER_COND: rd_mux = SEG_DW'(oper_cond);
            OFS_OPER_EVT:  rd_mux = SEG_DW'(oper_evt);
            OFS_OPER_EN:   rd_mux = SEG_DW'(oper_en_ff);
            OFS_OPER_RISE: rd_mux = SEG_DW'(oper_rise_ff);
            OFS_OPER_FALL: rd_mux = SEG_DW'(oper_fall_ff);
            OFS_QUES_COND: rd_mux = SEG_DW'(ques_cond);
            OFS_QUES_EVT:  rd_mux = SEG_DW'(ques_evt);
            OFS_QUES_EN:   rd_mux = SEG_DW'(ques_en_ff);
            OFS_QUES_RISE: rd_mux = SEG_DW'(ques_rise_ff);
            OFS_QUES_FALL: rd_mux = SEG_DW'(ques_fall_ff);
            OFS_STB:       rd_mux = SEG_DW'(stb);
            OFS_IRQ_STAT:  rd_mux = SEG_DW'(irq_stat_ff);
            OFS_IRQ_MASK:  rd_mux = SEG_DW'(irq_mask_ff);
            default:       rd_mux = {SEG_DW{1'b0}};
        endcase
    end

    // Data valid only in the cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata_ff <= RST_REG;
        end else begin
            rdata_ff <= req.rd ? rd_mux : RST_REG;
        end
    end

    assign rdata = rdata_ff;

endmodule : seg_top

// ---- core/seg_pkg.sv ----
package seg_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int SEG_DW = 16;
    localparam int SEG_AW = 5;

    // ------------------------------------------------------------
    // Register offsets (word index on the plain port)
    // ------------------------------------------------------------
    localparam logic [4:0] OFS_OPER_COND = 5'h00;
    localparam logic [4:0] OFS_OPER_EVT  = 5'h01;
    localparam logic [4:0] OFS_OPER_EN   = 5'h02;
    localparam logic [4:0] OFS_OPER_RISE = 5'h03;
    localparam logic [4:0] OFS_OPER_FALL = 5'h04;
    localparam logic [4:0] OFS_QUES_COND = 5'h05;
    localparam logic [4:0] OFS_QUES_EVT  = 5'h06;
    localparam logic [4:0] OFS_QUES_EN   = 5'h07;
    localparam logic [4:0] OFS_QUES_RISE = 5'h08;
    localparam logic [4:0] OFS_QUES_FALL = 5'h09;
    localparam logic [4:0] OFS_STB       = 5'h0A;
    localparam logic [4:0] OFS_IRQ_STAT  = 5'h0B;
    localparam logic [4:0] OFS_IRQ_MASK  = 5'h0C;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int POS_SWEEPING  = 3;
    localparam int POS_STB_QUES  = 3;
    localparam int POS_STB_OPER  = 7;
    localparam int IRQ_OPER      = 0;
    localparam int IRQ_QUES      = 1;
    localparam int IRQ_W         = 2;
    localparam logic [15:0] RST_REG = 16'h0000;
    localparam logic [1:0]  RST_IRQ = 2'h0;

    // ------------------------------------------------------------
    // Bus request carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic [SEG_AW-1:0] addr;
        logic [SEG_DW-1:0] wdata;
        logic              wr;
        logic              rd;
    } seg_req_t;

endpackage : seg_pkg

// ---- core/seg_group.sv ----
module seg_group
    import seg_pkg::*;
#(
    parameter int W = SEG_DW
) (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] cond,
    input  wire logic [W-1:0] rise_edge_filter,
    input  wire logic [W-1:0] fall_edge_filter,
    input  wire logic [W-1:0] enable,
    input  wire logic         evt_read,
    output logic      [W-1:0] event_reg,
    output logic              summary,
    output logic              new_event
);
    // ------------------------------------------------------------
    // Edge detection and latching
    // ------------------------------------------------------------
    logic [W-1:0] prev_ff;
    logic [W-1:0] evt_ff;
    logic [W-1:0] rose;
    logic [W-1:0] fell;
    logic [W-1:0] hit;
    logic [W-1:0] nxt_evt;

    assign rose = cond & ~prev_ff;
    assign fell = ~cond & prev_ff;
    // Only filtered edges reach the latch
    assign hit  = (rose & rise_edge_filter) | (fell & fall_edge_filter);
    // Read clears, but an edge in the read cycle survives
    assign nxt_evt = (evt_read ? {W{1'b0}} : evt_ff) | hit;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prev_ff <= W'(RST_REG);
            evt_ff  <= W'(RST_REG);
        end else begin
            prev_ff <= cond;
            evt_ff  <= nxt_evt;
        end
    end

    assign event_reg = evt_ff;
    assign summary   = |(evt_ff & enable);
    assign new_event = |hit;

endmodule : seg_group

// ---- testbench/seg_top_asserts.sv ----
module seg_top_asserts
    import seg_pkg::*;
#(
    parameter int W = SEG_DW
) (
    input wire logic              ref_clk,
    input wire logic              rst,
    input wire logic [W-1:0]      oper_state,
    input wire logic [W-1:0]      ques_state,
    input wire logic              sweeping,
    input wire logic [SEG_AW-1:0] addr,
    input wire logic [SEG_DW-1:0] wdata,
    input wire logic              wr,
    input wire logic              rd,
    input wire logic [SEG_DW-1:0] rdata,
    input wire logic [7:0]        status_byte,
    input wire logic              irq
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----
    // Settle counters
    // ----
    // Inputs pass two sync stages, so only settled reads are judged
    logic [W:0]   po_ff;
    logic [W-1:0] pq_ff;
    logic [2:0]   qo_ff, qq_ff, sw_ff;
    wire  [2:0]   nxt_qo = (rst || {oper_state, sweeping} != po_ff) ? 3'h0
                  : qo_ff + {2'h0, qo_ff != 3'h7};
    wire  [2:0]   nxt_qq = (rst || ques_state != pq_ff) ? 3'h0
                  : qq_ff + {2'h0, qq_ff != 3'h7};
    wire  [2:0]   nxt_sw = (rst || !sweeping) ? 3'h0
                  : sw_ff + {2'h0, sw_ff != 3'h3};
    wire          ev_o = rd && addr == OFS_OPER_EVT;
    always_ff @(posedge ref_clk) begin
        po_ff <= {oper_state, sweeping};
        pq_ff <= ques_state;
        qo_ff <= nxt_qo;
        qq_ff <= nxt_qq;
        sw_ff <= nxt_sw;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_sweep; rd && addr == OFS_OPER_COND && sw_ff == 3'h3
        |=> rdata[POS_SWEEPING]; endproperty
    a_sweep: assert property (p_sweep) else $error("sweep bit low");
    property p_cond; rd && addr == OFS_OPER_COND && po_ff == '0
        && qo_ff > 3'h1 |=> rdata == '0; endproperty
    a_cond: assert property (p_cond) else $error("cond not live");
    property p_clr; (ev_o && qo_ff > 3'h5) ##1 ev_o |=> rdata == '0;
    endproperty
    a_clr: assert property (p_clr) else $error("event not cleared");
    property p_so; ev_o && qo_ff > 3'h5 |=> !status_byte[POS_STB_OPER];
    endproperty
    a_so: assert property (p_so) else $error("oper summary stuck");
    property p_sq; rd && addr == OFS_QUES_EVT && qq_ff > 3'h5
        |=> !status_byte[POS_STB_QUES]; endproperty
    a_sq: assert property (p_sq) else $error("ques summary stuck");
    property p_st; rd && addr == OFS_OPER_EN && $past(wr, 2) && !$past(wr)
        && $past(addr, 2) == OFS_OPER_EN && !$past(rst) && !$past(rst, 2)
        |=> rdata == $past(wdata, 3); endproperty
    a_st: assert property (p_st) else $error("enable not stored");
    property p_um; rd && addr > OFS_IRQ_MASK |=> rdata == '0; endproperty
    a_um: assert property (p_um) else $error("unmapped read nonzero");
    property p_im; wr && addr == OFS_IRQ_MASK && wdata[1:0] == 2'h0
        |=> !irq; endproperty
    a_im: assert property (p_im) else $error("masked irq high");
    c_b2b: cover property (ev_o ##1 ev_o);
    c_irq: cover property (irq);
    c_sq: cover property (status_byte[POS_STB_QUES]);
endmodule : seg_top_asserts

bind seg_top seg_top_asserts #(.W(W)) u_chk (.ref_clk(ref_clk), .rst(rst),
    .oper_state(oper_state), .ques_state(ques_state), .sweeping(sweeping),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .status_byte(status_byte), .irq(irq));

// ---- testbench/seg_host.sv ----
module seg_host
    import seg_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic [SEG_DW-1:0] rdata,
    output logic      [SEG_AW-1:0] addr,
    output logic      [SEG_DW-1:0] wdata,
    output logic                   wr,
    output logic                   rd
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----
    // Host access
    // ----
    logic [SEG_DW-1:0] q_first;
    initial begin
        addr = '0;
        wdata = '0;
        wr = 1'h0;
        rd = 1'h0;
    end
    // Strobe held n cycles gives back-to-back reads; released lines invert
    task acc(input logic w, input logic [SEG_AW-1:0] a,
             input logic [SEG_DW-1:0] d, input int n,
             output logic [SEG_DW-1:0] q);
        @(posedge ref_clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk);
            if (i == n - 1) begin
                wr <= 1'h0;
                rd <= 1'h0;
                addr <= ~a;
                wdata <= ~d;
            end
            #1;
            q_first = q;
            q = rdata;
        end
    endtask : acc
endmodule : seg_host

// ---- testbench/seg_top_tb.sv ----
module seg_top_tb
    import seg_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic              ref_clk = 1'h0;
    logic              rst = 1'h1;
    logic              sweeping = 1'h0;
    logic              wr, rd, irq;
    logic [SEG_AW-1:0] addr, bs;
    logic [SEG_DW-1:0] oper_state = '0;
    logic [SEG_DW-1:0] ques_state = '0;
    logic [SEG_DW-1:0] wdata, rdata, q, r, f, en, a, b, e;
    logic [7:0]        status_byte;
    logic [SEG_AW-1:0] msk [6] = '{OFS_OPER_EN, OFS_OPER_RISE, OFS_OPER_FALL,
                                   OFS_QUES_EN, OFS_QUES_RISE, OFS_QUES_FALL};
    int                failures = 0;
    int                num_checks = 0;
    int                cyc = 0;
    always #25 ref_clk = ~ref_clk;
    seg_top #(.W(SEG_DW)) u_dut (.ref_clk(ref_clk), .rst(rst),
        .oper_state(oper_state), .ques_state(ques_state), .sweeping(sweeping),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .status_byte(status_byte), .irq(irq));
    seg_host u_host (.ref_clk(ref_clk), .rdata(rdata), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd));
    // ----
    // Helpers
    // ----
    function logic [SEG_DW-1:0] exp_evt(input logic [SEG_DW-1:0] o, n, pr, pf);
        return (~o & n & pr) | (o & ~n & pf);
    endfunction : exp_evt
    // Sweep pin stays low here and overrides operation state bit three
    function logic [SEG_DW-1:0] cnd(input int g, input logic [SEG_DW-1:0] x);
        return (g == 1) ? x : (x & ~(16'h0001 << POS_SWEEPING));
    endfunction : cnd
    task chk(input logic [SEG_DW-1:0] got, input logic [SEG_DW-1:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task summarize;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    task w1(input logic [SEG_AW-1:0] ad, input logic [SEG_DW-1:0] d);
        u_host.acc(1'h1, ad, d, 1, q);
    endtask : w1
    task r1(input logic [SEG_AW-1:0] ad, input int n);
        u_host.acc(1'h0, ad, '0, n, q);
    endtask : r1
    task st(input int g, input logic [SEG_DW-1:0] x);
        @(posedge ref_clk);
        if (g == 1) ques_state <= x;
        else oper_state <= x;
        repeat (8) @(posedge ref_clk);
        #1;
    endtask : st
    // Hang guard, far above the six hundred or so cycles the run needs
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            failures++;
            summarize();
        end
    end
    // ----
    // Scenarios
    // ----
    initial begin
        q = 16'($urandom(32'h773365a7));
        repeat (8) @(posedge ref_clk);
        rst <= 1'h0;
        for (int i = 0; i < 14; i++) begin
            r1(5'(i), 1);
            chk(q, '0);
        end
        for (int i = 0; i < 6; i++) begin
            a = 16'($urandom);
            w1(msk[i], a);
            r1(msk[i], 1);
            chk(q, a);
        end
        w1(OFS_OPER_RISE, 16'h0008);
        w1(OFS_OPER_FALL, 16'h0000);
        w1(OFS_OPER_EN, 16'h0008);
        w1(OFS_IRQ_MASK, 16'h0003);
        @(posedge ref_clk);
        sweeping <= 1'h1;
        st(0, '0);
        r1(OFS_OPER_COND, 1);
        chk(q, 16'h0008);
        chk(16'(status_byte[POS_STB_OPER]), 16'h0001);
        chk(16'(irq), 16'h0001);
        @(posedge ref_clk);
        sweeping <= 1'h0;
        st(0, '0);
        chk(16'(status_byte[POS_STB_OPER]), 16'h0001);
        r1(OFS_OPER_EVT, 2);
        chk(u_host.q_first, 16'h0008);
        chk(q, '0);
        chk(16'(status_byte[POS_STB_OPER]), '0);
        r1(OFS_IRQ_STAT, 1);
        chk(q, 16'h0001);
        w1(OFS_IRQ_MASK, '0);
        chk(16'(irq), '0);
        w1(OFS_IRQ_MASK, 16'h0003);
        chk(16'(irq), 16'h0001);
        w1(OFS_IRQ_STAT, 16'h0001);
        chk(16'(irq), '0);
        for (int g = 0; g < 2; g++) begin
            bs = (g == 1) ? OFS_QUES_COND : OFS_OPER_COND;
            for (int k = 0; k < 8; k++) begin
                r = (k == 0) ? '0 : 16'($urandom);
                f = (k == 0) ? '0 : 16'($urandom);
                en = (k == 1) ? '1 : 16'($urandom);
                a = 16'($urandom);
                b = (k == 2) ? ~a : 16'($urandom);
                w1(bs + 5'h02, en);
                w1(bs + 5'h03, r);
                w1(bs + 5'h04, f);
                st(g, a);
                r1(bs + 5'h01, 1);
                st(g, b);
                e = exp_evt(cnd(g, a), cnd(g, b), r, f);
                chk(16'(status_byte[g == 1 ? POS_STB_QUES : POS_STB_OPER]),
                    16'(|(e & en)));
                r1(bs + 5'h01, 1);
                chk(q, e);
                r1(bs, 1);
                chk(q, cnd(g, b));
            end
        end
        summarize();
    end
endmodule : seg_top_tb
